/* hdl/wdcr_pkg.sv */
// Constants, register map and state encoding for the watchdog and charger register slice.
`default_nettype none
package wdcr_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFF_WD_CLEAR = 8'h0D;
	localparam logic [7:0] OFF_LOCK_EN = 8'h10;
	localparam logic [7:0] OFF_CHG_CUR = 8'h11;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int WD_MSB = 2;
	localparam int KEY_MSB = 7;
	localparam int KEY_LSB = 3;
	localparam int NTC_BIT = 2;
	localparam int TMR_BIT = 1;
	localparam int EN_BIT = 0;
	localparam int ICHG_MSB = 5;

	// ****************************************
	// Codes and reset values
	// ****************************************
	localparam logic [2:0] WD_CODE = 3'h1;
	localparam logic [4:0] KEY_OPEN = 5'h15;
	localparam logic [4:0] KEY_DEF = 5'h00;
	localparam logic NTC_DEF = 1'b0;
	localparam logic TMR_DEF = 1'b1;
	localparam logic CHARGER_ON_DEF = 1'b1;
	localparam logic [5:0] ICHG_DEF = 6'h08;
	localparam logic [1:0] CUR_RSVD = 2'h0;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// ****************************************
	// Serial target states
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_DEVADDR = 4'h1,
		ST_ACK_DEV = 4'h3,
		ST_REGPTR = 4'h2,
		ST_ACK_REG = 4'h6,
		ST_WRDATA = 4'h7,
		ST_ACK_WR = 4'h5,
		ST_RDDATA = 4'h4,
		ST_RD_ACK = 4'hC,
		ST_IGNORE = 4'hD
	} wdcr_state_t;
endpackage
`default_nettype wire

/* hdl/wdcr_bus_if.sv */
// Synchronised two-wire bus events passed from the pin stage to the register slice.
`default_nettype none
interface wdcr_bus_if;
	logic scl_rise;
	logic scl_fall;
	logic sda;
	logic start;
	logic stop;
	modport src (
		output scl_rise,
		output scl_fall,
		output sda,
		output start,
		output stop
	);
	modport dst (
		input scl_rise,
		input scl_fall,
		input sda,
		input start,
		input stop
	);
endinterface
`default_nettype wire

/* hdl/wdcr_pin_sync.sv */
// Two-flop synchronisers and edge, start and stop detection for the bus pins.
`default_nettype none
module wdcr_pin_sync (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl_i,
	input wire logic sda_i,
	wdcr_bus_if.src ev
);
	// Stage 0 is the metastable flop; only stage 1 reads it, detection uses stages 1 and 2.
	typedef struct packed {
		logic [2:0] scl;
		logic [2:0] sda;
	} wdcr_sync_t;

	wdcr_sync_t q;
	wdcr_sync_t d;

	always_comb begin
		d = q;
		if (ce) begin
			d.scl = {q.scl[1:0], scl_i};
			d.sda = {q.sda[1:0], sda_i};
		end
	end

	// An idle bus floats high, so the chain starts high to avoid a false start.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '1;
		end else begin
			q <= d;
		end
	end

	assign ev.scl_rise = q.scl[1] & ~q.scl[2];
	assign ev.scl_fall = ~q.scl[1] & q.scl[2];
	assign ev.sda = q.sda[1];
	assign ev.start = q.scl[1] & q.scl[2] & ~q.sda[1] & q.sda[2];
	assign ev.stop = q.scl[1] & q.scl[2] & q.sda[1] & ~q.sda[2];
endmodule
`default_nettype wire

/* hdl/wdcr_top.sv */
// Two-wire target with the watchdog clear, charger lock and fast-charge current registers.
`default_nettype none
// ****************************************
// Register slice
// ****************************************
// Operation
// R1: Watchdog register write-only, clear field bits 2..0.
// R2: Writing code 001 clears the watchdog.
// R3: Any other code leaves the watchdog alone.
// R4: Lock key bits 7..3, opens at 10101.
// R5: Locked writes to protected register are dropped.
// R6: Lock register always readable and writable.
// R7: Bit 2 enables thermistor control, default 0.
// R8: Bit 1 enables both charge timers, default 1.
// R9: Bit 0 enables charger, default 1.
// R10: Current register writable only with key open.
// R11: Current code bits 5..0, default 001000.
// R12: Watchdog register reads zero; clear is pulse.
module wdcr_top #(
	parameter logic [6:0] DEV_ADDR = 7'h2A,
	parameter logic CHARGER_ON_RST = wdcr_pkg::CHARGER_ON_DEF,
	parameter logic [5:0] ICHG_RST = wdcr_pkg::ICHG_DEF
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic watchdog_clear,
	output logic thermistor_control_enable,
	output logic charge_timers_enable,
	output logic charger_enable,
	output logic [5:0] fast_charge_current_code
);
	// ****************************************
	// Parameter checks
	// ****************************************
	// The lowest eight target addresses are reserved on the bus and would never be answered.
	if (DEV_ADDR[6:3] == 4'h0) begin : g_bad_addr
		$error("DEV_ADDR falls in the reserved address range");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		wdcr_pkg::wdcr_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		logic [7:0] ptr;
		logic rw;
		logic mack;
		logic oe;
		logic wd;
		logic [4:0] key;
		logic ntc;
		logic tmr;
		logic en;
		logic [5:0] ichg;
	} wdcr_regs_t;

	wdcr_regs_t q;
	wdcr_regs_t d;
	wdcr_bus_if ev ();
	logic [7:0] rd_byte;
	logic wr_fire;
	logic key_open;
	logic lock_wr;
	logic cur_wr;
	logic wd_hit;
	logic [4:0] wr_key;
	logic [2:0] wr_en3;
	logic [5:0] wr_code;

	wdcr_pin_sync u_sync (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.ev(ev)
	);

	// ****************************************
	// Register access decode
	// ****************************************
	// The watchdog register has no storage behind it, so it reads as zero.
	assign rd_byte = (q.ptr == wdcr_pkg::OFF_LOCK_EN) ? {q.key, q.ntc, q.tmr, q.en} : // see R6
		(q.ptr == wdcr_pkg::OFF_CHG_CUR) ? {wdcr_pkg::CUR_RSVD, q.ichg} : // see R11
		wdcr_pkg::READ_ZERO; // see R1 see R12

	assign wr_fire = ce & (q.st == wdcr_pkg::ST_WRDATA) & ev.scl_fall
		& (q.cnt == wdcr_pkg::BYTE_BITS);
	assign key_open = (q.key == wdcr_pkg::KEY_OPEN); // see R4
	assign lock_wr = wr_fire & (q.ptr == wdcr_pkg::OFF_LOCK_EN);
	assign cur_wr = wr_fire & (q.ptr == wdcr_pkg::OFF_CHG_CUR);
	assign wr_key = q.sh[wdcr_pkg::KEY_MSB:wdcr_pkg::KEY_LSB];
	assign wr_en3 = q.sh[wdcr_pkg::NTC_BIT:wdcr_pkg::EN_BIT];
	assign wr_code = q.sh[wdcr_pkg::ICHG_MSB:0];
	assign wd_hit = wr_fire & (q.ptr == wdcr_pkg::OFF_WD_CLEAR)
		& (q.sh[wdcr_pkg::WD_MSB:0] == wdcr_pkg::WD_CODE); // see R2 see R3

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d = q;
		if (ce) begin
			d.wd = wd_hit; // see R12
			if (ev.scl_rise) begin
				d.sh = {q.sh[6:0], ev.sda};
				if (q.cnt != wdcr_pkg::BYTE_BITS) begin
					d.cnt = q.cnt + 4'h1;
				end
				if (q.st == wdcr_pkg::ST_RD_ACK) begin
					d.mack = ~ev.sda;
				end
			end
			if (ev.scl_fall) begin
				case (q.st)
				wdcr_pkg::ST_DEVADDR: begin
					if (q.cnt == wdcr_pkg::BYTE_BITS) begin
						d.cnt = 4'h0;
						if (q.sh[7:1] == DEV_ADDR) begin
							d.st = wdcr_pkg::ST_ACK_DEV;
							d.oe = 1'b1;
							d.rw = q.sh[0];
						end else begin
							d.st = wdcr_pkg::ST_IGNORE;
						end
					end
				end
				wdcr_pkg::ST_ACK_DEV: begin
					d.cnt = 4'h0;
					if (q.rw) begin
						d.st = wdcr_pkg::ST_RDDATA;
						d.tx = rd_byte;
						d.oe = ~rd_byte[7];
						d.ptr = q.ptr + 8'h01;
					end else begin
						d.st = wdcr_pkg::ST_REGPTR;
						d.oe = 1'b0;
					end
				end
				wdcr_pkg::ST_REGPTR: begin
					if (q.cnt == wdcr_pkg::BYTE_BITS) begin
						d.cnt = 4'h0;
						d.ptr = q.sh;
						d.st = wdcr_pkg::ST_ACK_REG;
						d.oe = 1'b1;
					end
				end
				wdcr_pkg::ST_ACK_REG, wdcr_pkg::ST_ACK_WR: begin
					d.cnt = 4'h0;
					d.st = wdcr_pkg::ST_WRDATA;
					d.oe = 1'b0;
				end
				wdcr_pkg::ST_WRDATA: begin
					if (q.cnt == wdcr_pkg::BYTE_BITS) begin
						d.cnt = 4'h0;
						d.ptr = q.ptr + 8'h01;
						d.st = wdcr_pkg::ST_ACK_WR;
						d.oe = 1'b1;
					end
				end
				wdcr_pkg::ST_RDDATA: begin
					if (q.cnt == wdcr_pkg::BYTE_BITS) begin
						d.cnt = 4'h0;
						d.st = wdcr_pkg::ST_RD_ACK;
						d.oe = 1'b0;
					end else begin
						d.tx = {q.tx[6:0], 1'b0};
						d.oe = ~q.tx[6];
					end
				end
				wdcr_pkg::ST_RD_ACK: begin
					d.cnt = 4'h0;
					if (q.mack) begin
						d.st = wdcr_pkg::ST_RDDATA;
						d.tx = rd_byte;
						d.oe = ~rd_byte[7];
						d.ptr = q.ptr + 8'h01;
					end else begin
						d.st = wdcr_pkg::ST_IGNORE;
					end
				end
				default: begin
					d.st = q.st;
				end
				endcase
			end
			// Reserved bits of every register are dropped on write.
			if (lock_wr) begin
				d.key = wr_key; // see R4 see R6
				d.ntc = wr_en3[wdcr_pkg::NTC_BIT]; // see R7
				d.tmr = wr_en3[wdcr_pkg::TMR_BIT]; // see R8
				d.en = wr_en3[wdcr_pkg::EN_BIT]; // see R9
			end
			// A closed key drops the write but the byte is still acknowledged.
			if (cur_wr && key_open) begin
				d.ichg = wr_code; // see R5 see R10 see R11
			end
			if (ev.start) begin
				d.st = wdcr_pkg::ST_DEVADDR;
				d.cnt = 4'h0;
				d.oe = 1'b0;
			end
			if (ev.stop) begin
				d.st = wdcr_pkg::ST_IDLE;
				d.oe = 1'b0;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q.st <= wdcr_pkg::ST_IDLE;
			q.cnt <= 4'h0;
			q.sh <= 8'h00;
			q.tx <= 8'h00;
			q.ptr <= 8'h00;
			q.rw <= 1'b0;
			q.mack <= 1'b0;
			q.oe <= 1'b0;
			q.wd <= 1'b0;
			q.key <= wdcr_pkg::KEY_DEF; // see R4
			q.ntc <= wdcr_pkg::NTC_DEF; // see R7
			q.tmr <= wdcr_pkg::TMR_DEF; // see R8
			q.en <= CHARGER_ON_RST; // see R9
			q.ichg <= ICHG_RST; // see R11
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Open-drain data line: only ever pulled low.
	assign sda_o = 1'b0;
	assign sda_oe = q.oe;
	assign watchdog_clear = q.wd;
	assign thermistor_control_enable = q.ntc;
	assign charge_timers_enable = q.tmr;
	assign charger_enable = q.en;
	assign fast_charge_current_code = q.ichg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	property p_rd_zero;
		q.ptr == wdcr_pkg::OFF_WD_CLEAR |-> rd_byte == 8'h00;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("watchdog register read not zero"); // see R1

	property p_wd_clear;
		wd_hit |=> watchdog_clear;
	endproperty
	a_wd_clear: assert property (p_wd_clear) else $error("clear code gave no pulse"); // see R2

	property p_wd_cause;
		$rose(watchdog_clear) |-> $past(wd_hit);
	endproperty
	a_wd_cause: assert property (p_wd_cause) else $error("watchdog cleared without code"); // see R3

	property p_wd_pulse;
		watchdog_clear && ce |=> !watchdog_clear;
	endproperty
	a_wd_pulse: assert property (p_wd_pulse) else $error("clear pulse too long"); // see R12

	property p_key_open;
		cur_wr && key_open |=> fast_charge_current_code == $past(wr_code);
	endproperty
	a_key_open: assert property (p_key_open) else $error("open key write lost"); // see R4

	property p_locked;
		cur_wr && !key_open |=> $stable(fast_charge_current_code);
	endproperty
	a_locked: assert property (p_locked) else $error("locked write took effect"); // see R5

	property p_lock_reg;
		lock_wr |=> q.key == $past(wr_key);
	endproperty
	a_lock_reg: assert property (p_lock_reg) else $error("lock key not written"); // see R6

	property p_ntc;
		$changed(thermistor_control_enable) |-> $past(lock_wr);
	endproperty
	a_ntc: assert property (p_ntc) else $error("thermistor enable changed unasked"); // see R7

	property p_timers;
		lock_wr |=> {thermistor_control_enable, charge_timers_enable, charger_enable}
			== $past(wr_en3);
	endproperty
	a_timers: assert property (p_timers) else $error("enable bits not written"); // see R8

	property p_charger_enable;
		$changed(charger_enable) |-> $past(lock_wr);
	endproperty
	a_charger_enable: assert property (p_charger_enable) else $error("charger enable changed unasked"); // see R9

	property p_cur_cause;
		$changed(fast_charge_current_code) |-> $past(cur_wr && key_open);
	endproperty
	a_cur_cause: assert property (p_cur_cause) else $error("current code changed unasked"); // see R10

	property p_cur_read;
		q.ptr == wdcr_pkg::OFF_CHG_CUR |-> rd_byte == {2'h0, fast_charge_current_code};
	endproperty
	a_cur_read: assert property (p_cur_read) else $error("current register readback wrong"); // see R11

	property p_c_wd;
		wd_hit;
	endproperty
	c_wd: cover property (p_c_wd);

	property p_c_locked;
		cur_wr && !key_open;
	endproperty
	c_locked: cover property (p_c_locked);

	property p_c_open;
		cur_wr && key_open;
	endproperty
	c_open: cover property (p_c_open);

	property p_c_read;
		q.st == wdcr_pkg::ST_RD_ACK && ev.scl_fall && q.mack;
	endproperty
	c_read: cover property (p_c_read);
endmodule
`default_nettype wire

/* bench/wdcr_host.sv */
// Two-wire bus host model driving the pins of the register slice.
`default_nettype none
module wdcr_host (
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// ****
	// Framing
	// ****
	// The long wait lets the target drop its acknowledge before SCL rises.
	task automatic start;
		sda_low = 1'b0;
		w(8);
		scl = 1'b1;
		w(8);
		sda_low = 1'b1;
		w(8);
		scl = 1'b0;
	endtask
	task automatic stop;
		w(4);
		sda_low = 1'b1;
		w(4);
		scl = 1'b1;
		w(8);
		sda_low = 1'b0;
		w(8);
	endtask
	task automatic bit_x(input logic b, output logic s);
		w(4);
		sda_low = ~b;
		w(4);
		scl = 1'b1;
		w(8);
		s = sda;
		scl = 1'b0;
	endtask
	// A one on the data slot releases the line, so reads pass 8'hFF.
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(a, k);
	endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the watchdog and charger register slice.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] ADDR = 7'h2A;
	typedef struct packed {
		logic [7:0] p;
		logic [7:0] d;
		logic [7:0] rb;
		logic [8:0] o;
		logic [1:0] n;
	} wdcr_row_t;
	localparam wdcr_row_t ROWS [7] = '{
		'{8'h11, 8'h3F, 8'h08, 9'h0C8, 2'h0},
		'{8'h10, 8'hAF, 8'hAF, 9'h1C8, 2'h0},
		'{8'h11, 8'hFF, 8'h3F, 9'h1FF, 2'h0},
		'{8'h10, 8'hA8, 8'hA8, 9'h03F, 2'h0},
		'{8'h10, 8'h00, 8'h00, 9'h03F, 2'h0},
		'{8'h11, 8'h05, 8'h3F, 9'h03F, 2'h0},
		'{8'h0D, 8'hF9, 8'h00, 9'h03F, 2'h1}
	};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic scl, h_low, sda_o, sda_oe, wdc, ntc, tmr, chg, k;
	logic [5:0] code;
	logic [7:0] q;
	int err_count = 0;
	int checks_done = 0;
	int pulses = 0;
	int c0;
	// Open-drain data line with a pull-up.
	wire logic sda = ~(h_low | (sda_oe & ~sda_o));
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		if (wdc === 1'b1) begin
			pulses <= pulses + 1;
		end
	end
	wdcr_top #(.DEV_ADDR(ADDR)) u_wdcr_top (.mclk(mclk), .rst(rst), .ce(ce),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.watchdog_clear(wdc), .thermistor_control_enable(ntc),
		.charge_timers_enable(tmr), .charger_enable(chg),
		.fast_charge_current_code(code));
	wdcr_host u_wdcr_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(h_low));
	// ****
	// Checking and bus tasks
	// ****
	task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic tx(input logic [7:0] d, input logic e);
		u_wdcr_host.xfer(d, 1'b1, q, k);
		chk("ack", {8'h00, k}, {8'h00, e});
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		u_wdcr_host.start;
		tx({ADDR, 1'b0}, 1'b0);
		tx(p, 1'b0);
		tx(d, 1'b0);
		u_wdcr_host.stop;
	endtask
	task automatic rd(input logic [7:0] p);
		u_wdcr_host.start;
		tx({ADDR, 1'b0}, 1'b0);
		tx(p, 1'b0);
		u_wdcr_host.start;
		tx({ADDR, 1'b1}, 1'b0);
		u_wdcr_host.xfer(8'hFF, 1'b1, q, k);
		u_wdcr_host.stop;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge mclk);
		err_count++;
		tally_and_finish;
	end
	// ****
	// Sequence
	// ****
	initial begin
		repeat (10) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		chk("outs", {ntc, tmr, chg, code}, 9'h0C8);
		rd(8'h10);
		chk("lock reg", {1'b0, q}, 9'h003);
		rd(8'h11);
		chk("cur reg", {1'b0, q}, 9'h008);
		$display("test reset done");
		for (int i = 0; i < 7; i++) begin
			c0 = pulses;
			wr(ROWS[i].p, ROWS[i].d);
			rd(ROWS[i].p);
			chk("readback", {1'b0, q}, {1'b0, ROWS[i].rb});
			chk("outs", {ntc, tmr, chg, code}, ROWS[i].o);
			chk("pulses", 9'(pulses - c0), {7'h00, ROWS[i].n});
		end
		$display("test rows done");
		for (int c = 0; c < 8; c++) begin
			c0 = pulses;
			wr(8'h0D, 8'(c));
			chk("pulses", 9'(pulses - c0), (c == 1) ? 9'h001 : 9'h000);
		end
		$display("test clear codes done");
		// A frozen target must neither answer nor take the byte.
		ce = 1'b0;
		u_wdcr_host.start;
		tx({ADDR, 1'b0}, 1'b1);
		tx(8'h10, 1'b1);
		tx(8'h07, 1'b1);
		u_wdcr_host.stop;
		ce = 1'b1;
		chk("frozen outs", {ntc, tmr, chg, code}, 9'h03F);
		$display("test clock enable done");
		wr(8'h10, 8'h07);
		u_wdcr_host.start;
		tx({ADDR, 1'b0}, 1'b0);
		tx(8'h10, 1'b0);
		u_wdcr_host.start;
		tx({ADDR, 1'b1}, 1'b0);
		u_wdcr_host.xfer(8'hFF, 1'b0, q, k);
		chk("burst lock", {1'b0, q}, 9'h007);
		u_wdcr_host.xfer(8'hFF, 1'b1, q, k);
		chk("burst cur", {1'b0, q}, 9'h03F);
		u_wdcr_host.stop;
		chk("outs", {ntc, tmr, chg, code}, 9'h1FF);
		$display("test burst read done");
		u_wdcr_host.start;
		tx({7'h2B, 1'b0}, 1'b1);
		u_wdcr_host.stop;
		$display("test foreign address done");
		rst = 1'b1;
		repeat (10) @(negedge mclk);
		chk("outs", {ntc, tmr, chg, code}, 9'h0C8);
		chk("clear", {8'h00, wdc}, 9'h000);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		wr(8'h11, 8'h3F);
		chk("outs", {ntc, tmr, chg, code}, 9'h0C8);
		$display("test second reset done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
